// *** logic/sasx_exec.sv ***
// Purpose: Executes three subtract instructions and the sleep entry instruction
// Assumes: One instruction per cycle on op_valid; file register read data arrives with it
// Notes:   Asleep state holds until wake; all ops ignored while asleep
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps

// Contract
// - Subtract-from-literal computes literal minus accumulator and writes the accumulator.
// - For that op carry is 0 when acc exceeds literal and digit carry is 0 when acc low nibble exceeds literal's.
// - Every subtract updates carry, digit carry and zero and no other status flag.
// - Subtract-from-register computes register minus accumulator, result to acc when dest is 0 else register.
// - Subtract-with-borrow computes register minus acc minus inverted carry, routed by dest the same way.
// - Sleep clears the active-low power-down flag and sets the active-low time-out flag.
// - Sleep clears the watchdog counter and its prescaler; this block only raises watchdog_clear for one cycle and holds no counter.
// - After sleep the oscillator stops and execution halts.
module sasx_exec (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic                      op_valid,
    input  wire sasx_pkg::sasx_op_type     op_code,
    input  wire logic [7:0]                literal,
    input  wire logic [6:0]                reg_addr,
    input  wire logic                      dest_sel,
    input  wire logic [7:0]                reg_rdata,
    input  wire logic                      wake,
    output logic [7:0]                     acc,
    output logic                           carry_flag,
    output logic                           digit_carry_flag,
    output logic                           zero_flag,
    output logic                           power_down_flag_n,
    output logic                           time_out_flag_n,
    output logic                           reg_we,
    output logic [6:0]                     reg_waddr,
    output logic [7:0]                     reg_wdata,
    output logic                           watchdog_clear,
    output logic                           osc_run,
    output logic                           core_halted
);
    typedef struct packed {
        sasx_pkg::sasx_state_type st;
        logic [7:0]               acc;
        logic                     c;
        logic                     digc;
        logic                     z;
        logic                     pwr_dn_n;
        logic                     tmo_n;
        logic                     we;
        logic [6:0]               waddr;
        logic [7:0]               wdata;
        logic                     wdog_clr;
    } sasx_regs_type;

    sasx_regs_type s_r;
    sasx_regs_type s_nxt;

    logic [8:0] diff;
    logic [4:0] ldiff;
    logic [7:0] mnd;
    logic       bin;
    logic       is_sub;

    // True for the three subtract codes; sleep, no-op and spare codes fall out
    function automatic logic is_subtract(input sasx_pkg::sasx_op_type op);
        return op == sasx_pkg::SASX_OP_SUBLT || op == sasx_pkg::SASX_OP_SUBRG
               || op == sasx_pkg::SASX_OP_SUBBR;
    endfunction

    always_comb begin
        s_nxt          = s_r;
        s_nxt.we       = 1'b0;
        s_nxt.wdog_clr = 1'b0;
        mnd    = (op_code == sasx_pkg::SASX_OP_SUBLT) ? literal : reg_rdata;
        bin    = (op_code == sasx_pkg::SASX_OP_SUBBR) ? ~s_r.c : 1'b0;
        // Nine-bit difference; bit 8 clear means no borrow, i.e. carry set
        diff   = {1'b0, mnd} - {1'b0, s_r.acc} - {8'h00, bin};
        // Low nibble takes the same borrow so digit carry tracks the full subtract
        ldiff  = {1'b0, mnd[3:0]} - {1'b0, s_r.acc[3:0]} - {4'h0, bin};
        is_sub = op_valid && s_r.st == sasx_pkg::SASX_RUN && is_subtract(op_code);
        if (is_sub) begin
            s_nxt.c    = ~diff[8];
            s_nxt.digc = ~ldiff[4];
            s_nxt.z    = (diff[7:0] == sasx_pkg::ACC_ZERO);
            if (op_code == sasx_pkg::SASX_OP_SUBLT || !dest_sel) begin
                s_nxt.acc = diff[7:0];
            end else begin
                s_nxt.we    = 1'b1;
                s_nxt.waddr = reg_addr;
                s_nxt.wdata = diff[7:0];
            end
        end
        unique case (s_r.st)
            sasx_pkg::SASX_RUN: begin
                if (op_valid && op_code == sasx_pkg::SASX_OP_SLEEP) begin
                    s_nxt.pwr_dn_n = 1'b0;
                    s_nxt.tmo_n    = 1'b1;
                    s_nxt.wdog_clr = 1'b1;
                    s_nxt.st       = sasx_pkg::SASX_ASLP;
                end
            end
            sasx_pkg::SASX_ASLP: begin
                if (wake) begin
                    s_nxt.st = sasx_pkg::SASX_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r.st       <= sasx_pkg::SASX_RUN;
            s_r.acc      <= sasx_pkg::ACC_RST;
            s_r.c        <= sasx_pkg::CARRY_RST;
            s_r.digc     <= sasx_pkg::DIGIT_CARRY_RST;
            s_r.z        <= sasx_pkg::ZERO_RST;
            s_r.pwr_dn_n <= sasx_pkg::POWER_DOWN_N_RST;
            s_r.tmo_n    <= sasx_pkg::TIME_OUT_N_RST;
            s_r.we       <= sasx_pkg::WRITE_EN_RST;
            s_r.waddr    <= sasx_pkg::WADDR_RST;
            s_r.wdata    <= sasx_pkg::WDATA_RST;
            s_r.wdog_clr <= sasx_pkg::WDOG_CLR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign acc               = s_r.acc;
    assign carry_flag        = s_r.c;
    assign digit_carry_flag  = s_r.digc;
    assign zero_flag         = s_r.z;
    assign power_down_flag_n = s_r.pwr_dn_n;
    assign time_out_flag_n   = s_r.tmo_n;
    assign reg_we            = s_r.we;
    assign reg_waddr         = s_r.waddr;
    assign reg_wdata         = s_r.wdata;
    assign watchdog_clear    = s_r.wdog_clr;
    assign osc_run           = (s_r.st == sasx_pkg::SASX_RUN);
    assign core_halted       = (s_r.st == sasx_pkg::SASX_ASLP);

    sequence sleep_cmd_s;
        op_valid && op_code == sasx_pkg::SASX_OP_SLEEP && osc_run;
    endsequence

    sequence sleep_effect_s;
        !power_down_flag_n && time_out_flag_n && watchdog_clear && core_halted && !osc_run;
    endsequence

    // Subtract that sends its result to the file register instead of the accumulator
    sequence sub_write_s;
        op_valid && osc_run && dest_sel
        && (op_code == sasx_pkg::SASX_OP_SUBRG || op_code == sasx_pkg::SASX_OP_SUBBR);
    endsequence

    sequence write_back_s;
        reg_we && reg_waddr == $past(reg_addr) && $stable(acc);
    endsequence

    sequence wake_cmd_s;
        core_halted && wake;
    endsequence

    AST_SUBLT_RES: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBLT |=> acc == 8'($past(literal) - $past(acc)))
        else $error("literal subtract result wrong");
    AST_SUBLT_C: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBLT |=> carry_flag == ($past(acc) <= $past(literal)))
        else $error("literal subtract carry wrong");
    AST_SUBLT_DC: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBLT
        |=> digit_carry_flag == ($past(acc[3:0]) <= $past(literal[3:0])))
        else $error("literal subtract digit carry wrong");
    AST_SUB_KEEPS: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code != sasx_pkg::SASX_OP_SLEEP |=> $stable(power_down_flag_n) && $stable(time_out_flag_n))
        else $error("subtract touched power status");
    AST_SUBRG_DEST: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBRG && dest_sel
        |=> reg_we && reg_wdata == 8'($past(reg_rdata) - $past(acc)) && $stable(acc))
        else $error("register subtract writeback wrong");
    AST_SUBBR_RES: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBBR && !dest_sel
        |=> acc == 8'($past(reg_rdata) - $past(acc) - {7'h00, ~$past(carry_flag)}))
        else $error("borrow subtract result wrong");
    AST_SLEEP: assert property (@(posedge ref_clk) disable iff (rst)
        sleep_cmd_s |=> sleep_effect_s)
        else $error("sleep entry effects wrong");
    AST_WATCHDOG_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
        watchdog_clear |=> !watchdog_clear)
        else $error("watchdog clear not a single pulse");
    AST_HALT: assert property (@(posedge ref_clk) disable iff (rst)
        core_halted && !wake |=> core_halted && !reg_we && $stable(acc))
        else $error("core ran while asleep");
    AST_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBLT |=> zero_flag == (acc == 8'h00))
        else $error("zero flag wrong");

    AST_SUBRG_ACC: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBRG && !dest_sel
        |=> acc == 8'($past(reg_rdata) - $past(acc)) && !reg_we)
        else $error("register subtract result wrong");
    AST_SUBRG_C: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBRG
        |=> carry_flag == ($past(acc) <= $past(reg_rdata))
            && digit_carry_flag == ($past(acc[3:0]) <= $past(reg_rdata[3:0])))
        else $error("register subtract flags wrong");
    AST_SUBBR_DEST: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBBR && dest_sel
        |=> reg_we && $stable(acc)
            && reg_wdata == 8'($past(reg_rdata) - $past(acc) - {7'h00, ~$past(carry_flag)}))
        else $error("borrow subtract writeback wrong");
    AST_SUBBR_C: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && op_code == sasx_pkg::SASX_OP_SUBBR
        |=> carry_flag == ({1'b0, $past(acc)} + {8'h00, ~$past(carry_flag)} <= {1'b0, $past(reg_rdata)}))
        else $error("borrow subtract carry wrong");
    AST_WRITE_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
        sub_write_s |=> write_back_s)
        else $error("register write address wrong");
    AST_ZERO_WB: assert property (@(posedge ref_clk) disable iff (rst)
        sub_write_s |=> zero_flag == (reg_wdata == sasx_pkg::ACC_ZERO))
        else $error("zero flag wrong on write back");
    AST_SLEEP_KEEPS: assert property (@(posedge ref_clk) disable iff (rst)
        sleep_cmd_s |=> $stable(carry_flag) && $stable(digit_carry_flag) && $stable(zero_flag) && $stable(acc))
        else $error("sleep touched arithmetic state");
    AST_NO_OP: assert property (@(posedge ref_clk) disable iff (rst)
        op_valid && osc_run && !is_subtract(op_code) && op_code != sasx_pkg::SASX_OP_SLEEP
        |=> $stable(acc) && $stable(carry_flag) && $stable(zero_flag) && !reg_we)
        else $error("idle code changed state");
    AST_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
        wake_cmd_s |=> osc_run && !core_halted)
        else $error("core did not wake");
endmodule

// *** logic/sasx_pkg.sv ***
// Purpose: Shared constants and types for the subtract and sleep execution block
// Assumes: 8-bit data path, 7-bit file register address
// Notes:   Operation codes are local to this block
package sasx_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;

    typedef enum logic [2:0] {
        SASX_OP_NONE  = 3'h0,
        SASX_OP_SUBLT = 3'h1,
        SASX_OP_SUBRG = 3'h2,
        SASX_OP_SUBBR = 3'h3,
        SASX_OP_SLEEP = 3'h4
    } sasx_op_type;

    typedef enum logic [0:0] {
        SASX_RUN   = 1'b0,
        SASX_ASLP  = 1'b1
    } sasx_state_type;

    localparam logic [7:0] ACC_RST      = 8'h00;
    localparam logic [7:0] WDOG_CNT_CLR     = 8'h00;
    localparam logic [7:0] PRESCALE_CLR     = 8'h00;
    localparam logic       CARRY_RST        = 1'b0;
    localparam logic       DIGIT_CARRY_RST  = 1'b0;
    localparam logic       ZERO_RST         = 1'b0;
    localparam logic       POWER_DOWN_N_RST = 1'b1;
    localparam logic       TIME_OUT_N_RST   = 1'b1;
    localparam logic       WRITE_EN_RST     = 1'b0;
    localparam logic [6:0] WADDR_RST        = 7'h00;
    localparam logic [7:0] WDATA_RST        = 8'h00;
    localparam logic       WDOG_CLR_RST     = 1'b0;
    localparam logic [7:0] ACC_ZERO     = 8'h00;
endpackage

// *** tb/sasx_exec_tb.sv ***
// Purpose: Self-checking bench for the subtract and sleep execution block
// Assumes: Expected values come from a small accumulator and carry model kept here
// Notes:   Each op is driven one edge ahead and judged just after the edge that takes it
`timescale 1ns/1ps
module sasx_exec_tb;
    logic                  ref_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  op_valid = 1'b0;
    sasx_pkg::sasx_op_type op_code = sasx_pkg::SASX_OP_NONE;
    logic [7:0]            literal = 8'h00;
    logic [6:0]            reg_addr = 7'h00;
    logic                  dest_sel = 1'b0;
    logic [7:0]            reg_rdata = 8'h00;
    logic                  wake = 1'b0;
    logic [7:0]            acc, reg_wdata;
    logic [6:0]            reg_waddr;
    logic                  carry_flag, digit_carry_flag, zero_flag, power_down_flag_n, time_out_flag_n;
    logic                  reg_we, watchdog_clear, osc_run, core_halted;
    logic [7:0]            m_acc = 8'h00;
    logic                  m_c = 1'b0;
    logic                  m_pwr_dn = 1'b1;
    int                    err_total = 0;
    int                    n_checks = 0;
    int                    cyc = 0;

    sasx_exec dut (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .literal(literal),
        .reg_addr(reg_addr), .dest_sel(dest_sel), .reg_rdata(reg_rdata), .wake(wake), .acc(acc),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
        .power_down_flag_n(power_down_flag_n), .time_out_flag_n(time_out_flag_n), .reg_we(reg_we),
        .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .watchdog_clear(watchdog_clear),
        .osc_run(osc_run), .core_halted(core_halted));

    always #4 ref_clk = ~ref_clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard: whole run needs well under a hundred cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic do_op(input sasx_pkg::sasx_op_type op, input logic [7:0] opnd, input logic d);
        logic [8:0] r;
        logic [4:0] ln;
        logic       b;
        logic       wr;
        b  = (op == sasx_pkg::SASX_OP_SUBBR) ? !m_c : 1'b0;
        r  = {1'b0, opnd} - {1'b0, m_acc} - {8'h00, b};
        ln = {1'b0, opnd[3:0]} - {1'b0, m_acc[3:0]} - {4'h0, b};
        wr = d && (op != sasx_pkg::SASX_OP_SUBLT);
        @(posedge ref_clk);
        op_valid  <= 1'b1;
        op_code   <= op;
        literal   <= opnd;
        reg_rdata <= opnd;
        reg_addr  <= ~opnd[6:0];
        dest_sel  <= d;
        @(posedge ref_clk);
        op_valid  <= 1'b0;
        #1;
        if (!wr) begin
            m_acc = r[7:0];
        end
        m_c = !r[8];
        check("acc", acc, m_acc);
        check("carry", carry_flag, m_c);
        check("digit_carry", digit_carry_flag, !ln[4]);
        check("zero", zero_flag, r[7:0] == 8'h00);
        check("power_down_n", power_down_flag_n, m_pwr_dn);
        check("reg_we", reg_we, wr);
        if (wr) begin
            check("reg_waddr", reg_waddr, {1'b0, ~opnd[6:0]});
            check("reg_wdata", reg_wdata, r[7:0]);
        end
        @(posedge ref_clk);
        #1;
        check("reg_we_end", reg_we, 8'h00);
    endtask

    task automatic test_literal();
        do_op(sasx_pkg::SASX_OP_SUBLT, 8'h05, 1'b1);
        do_op(sasx_pkg::SASX_OP_SUBLT, 8'h03, 1'b0);
        do_op(sasx_pkg::SASX_OP_SUBLT, 8'hFE, 1'b0);
        do_op(sasx_pkg::SASX_OP_SUBLT, 8'hFF, 1'b0);
        $display("test literal done");
    endtask

    task automatic test_register();
        do_op(sasx_pkg::SASX_OP_SUBRG, 8'h80, 1'b1);
        do_op(sasx_pkg::SASX_OP_SUBRG, 8'h12, 1'b0);
        do_op(sasx_pkg::SASX_OP_SUBRG, 8'h12, 1'b0);
        $display("test register done");
    endtask

    // No-op and a spare code must leave everything alone
    task automatic test_refuse();
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_code  <= sasx_pkg::SASX_OP_NONE;
        dest_sel <= 1'b1;
        @(posedge ref_clk);
        op_code  <= sasx_pkg::sasx_op_type'(3'h5);
        @(posedge ref_clk);
        op_valid <= 1'b0;
        #1;
        check("acc_refused", acc, m_acc);
        check("carry_refused", carry_flag, m_c);
        check("we_refused", reg_we, 8'h00);
        @(posedge ref_clk);
        $display("test refuse done");
    endtask

    task automatic test_borrow();
        do_op(sasx_pkg::SASX_OP_SUBLT, 8'h10, 1'b0);
        do_op(sasx_pkg::SASX_OP_SUBBR, 8'h05, 1'b1);
        do_op(sasx_pkg::SASX_OP_SUBBR, 8'h10, 1'b1);
        do_op(sasx_pkg::SASX_OP_SUBBR, 8'h11, 1'b0);
        do_op(sasx_pkg::SASX_OP_SUBBR, 8'h00, 1'b0);
        // Carry set going in, so no borrow is taken
        do_op(sasx_pkg::SASX_OP_SUBLT, 8'hFF, 1'b0);
        do_op(sasx_pkg::SASX_OP_SUBBR, 8'h20, 1'b0);
        $display("test borrow done");
    endtask

    task automatic test_sleep();
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_code  <= sasx_pkg::SASX_OP_SLEEP;
        @(posedge ref_clk);
        op_code  <= sasx_pkg::SASX_OP_SUBLT;
        literal  <= 8'h77;
        #1;
        m_pwr_dn = 1'b0;
        check("power_down_n", power_down_flag_n, 8'h00);
        check("time_out_n", time_out_flag_n, 8'h01);
        check("wdog_clear", watchdog_clear, 8'h01);
        check("osc_run", osc_run, 8'h00);
        check("halted", core_halted, 8'h01);
        @(posedge ref_clk);
        op_valid <= 1'b0;
        wake     <= 1'b1;
        #1;
        check("wdog_end", watchdog_clear, 8'h00);
        check("acc_asleep", acc, m_acc);
        @(posedge ref_clk);
        wake     <= 1'b0;
        #1;
        check("osc_wake", osc_run, 8'h01);
        do_op(sasx_pkg::SASX_OP_SUBLT, 8'h40, 1'b0);
        $display("test sleep done");
    endtask

    // Mid-run reset must bring the power-down flag back after sleep
    task automatic test_reset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        m_acc    = sasx_pkg::ACC_RST;
        m_c      = sasx_pkg::CARRY_RST;
        m_pwr_dn = sasx_pkg::POWER_DOWN_N_RST;
        check("acc_rerst", acc, m_acc);
        check("carry_rerst", carry_flag, m_c);
        check("power_down_rerst", power_down_flag_n, m_pwr_dn);
        check("time_out_rerst", time_out_flag_n, sasx_pkg::TIME_OUT_N_RST);
        check("osc_rerst", osc_run, 8'h01);
        do_op(sasx_pkg::SASX_OP_SUBLT, 8'h09, 1'b0);
        $display("test reset done");
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check("acc_rst", acc, sasx_pkg::ACC_RST);
        check("osc_rst", osc_run, 8'h01);
        test_literal();
        test_register();
        test_refuse();
        test_borrow();
        test_sleep();
        test_reset();
        finish_test();
    end
endmodule
